// [design/dhp_regs.svh]
// Register offsets, field positions and reset values of the host bus port.
// Assumes inclusion by bare name from the package and the bench.
`ifndef DHP_REGS_SVH
`define DHP_REGS_SVH

// ------------------------------------------------------------------
// Offsets held in this block on the five address lines
// ------------------------------------------------------------------
`define DHP_ADDR_W         5
`define DHP_OFS_CONFIG     5'h08
`define DHP_OFS_INT_EN     5'h09
`define DHP_OFS_INT_STAT   5'h0a
`define DHP_OFS_FIFO       5'h10

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define DHP_CFG_STROBE_DIR 0
`define DHP_IEN_MASK_LSB   0
`define DHP_IEN_MASK_MSB   7
`define DHP_IEN_CNT_LSB    8
`define DHP_IEN_CNT_MSB    12
`define DHP_CNT_W          5

// ------------------------------------------------------------------
// Reset values and bus constants
// ------------------------------------------------------------------
`define DHP_CONFIG_RST     16'h0000
`define DHP_INT_EN_RST     16'h0000
`define DHP_INT_STAT_RST   8'h00
`define DHP_OE_NONE        16'hffff
`define DHP_OE_BYTE        16'hff00
`define DHP_OE_WORD        16'h0000
`define DHP_FIFO_DEPTH     16

`endif

// [design/dhp_pkg.sv]
// Types shared by the host bus port modules.
// Assumes dhp_regs.svh is on the include path.
`include "dhp_regs.svh"

package dhp_pkg;

	// ------------------------------------------------------------------
	// Conversion trigger sequencer states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		DHP_IDLE = 3'b001,
		DHP_HOLD = 3'b010,
		DHP_RUN  = 3'b100
	} dhp_trig_t;

	typedef logic [`DHP_ADDR_W-1:0] dhp_addr_t;

endpackage

// [design/dhp_flag.sv]
// One sticky interrupt flag: hardware set, bulk clear by a status read.
// Assumes set and clear are single-cycle pulses on clk_sys.
`timescale 1ns/1ps

module dhp_flag (
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_r
);

	// Set wins over clear so an event in the clearing cycle is kept
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			flag_r <= 1'b0;
		end else if (set) begin
			flag_r <= 1'b1;
		end else if (clr) begin
			flag_r <= 1'b0;
		end
	end

endmodule // dhp_flag

// [design/dhp_fifo.sv]
// Result buffer: flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall so the buffer really fills.
`timescale 1ns/1ps

module dhp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = `DHP_FIFO_DEPTH
) (
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	input  wire logic                     in_valid,
	output logic                          in_ready,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          out_valid,
	input  wire logic                     out_ready,
	output logic [WIDTH-1:0]              out_data,
	output logic [$clog2(DEPTH+1)-1:0]    count
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	// Elaboration check on the shape
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad
		$error("dhp_fifo: DEPTH must be >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [CW-1:0]    count_r;
	logic             push;
	logic             pop;

	// Honest flags straight from the occupancy count
	assign in_ready  = (count_r != CW'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign count     = count_r;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage, written by index
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	// Pointers wrap at DEPTH, which need not be a power of two
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0
				            : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0
				            : rd_ptr_r + 1'b1;
			end
		end
	end

	// Occupancy
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			count_r <= '0;
		end else if (push && !pop) begin
			count_r <= count_r + 1'b1;
		end else if (pop && !push) begin
			count_r <= count_r - 1'b1;
		end
	end

endmodule // dhp_fifo

// [design/dhp_port.sv]
// Host bus port of the acquisition converter: strobes, address latch,
// 8/16-bit data lanes, interrupt, transfer request and conversion strobe.
// Assumes all pins are already synchronous to clk_sys; the pin wire level
// is resolved outside from the active-low output enables.
//
// Behaviour
// - Width select high: low byte only, upper lines released
// - Width select low: full sixteen-bit data exchange
// - Drive data only while read and select low
// - Take bus data only while write and select low
// - Select low freezes conversion clocking, resumes after
// - Latch address on falling address strobe
// - Input strobe rising edge triggers sample-and-hold
// - Next edge after hold starts conversion or compare
// - Output strobe high from start until completion
// - Reset makes the conversion strobe an input
// - Unmasked interrupt condition drives interrupt low
// - Status read clears pending interrupts, releases output
// - Request rises when buffer count equals threshold
// - Request falls once the buffer is empty
`timescale 1ns/1ps

module dhp_port
	import dhp_pkg::*;
#(
	parameter int DEPTH = `DHP_FIFO_DEPTH
) (
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic                  bus_width_select,
	input  wire logic                  cs_n,
	input  wire logic                  rd_n,
	input  wire logic                  wr_n,
	input  wire logic                  ale,
	input  wire dhp_pkg::dhp_addr_t    register_address_lines,
	input  wire logic [15:0]           data_in,
	output logic [15:0]                data_out,
	output logic [15:0]                data_oe_n,
	input  wire logic                  conv_strobe_in,
	output logic                       conv_strobe_out,
	output logic                       conv_strobe_oe_n,
	output logic                       int_n,
	output logic                       transfer_request,
	output logic                       clk_freeze,
	output logic                       sh_hold,
	output logic                       start_conv,
	output logic                       start_cmp,
	input  wire logic                  instr_is_compare,
	input  wire logic                  op_start,
	input  wire logic                  op_done,
	input  wire logic [7:0]            irq_event,
	input  wire logic                  res_valid,
	output logic                       res_ready,
	input  wire logic [15:0]           res_data,
	output dhp_pkg::dhp_addr_t         reg_addr,
	output logic                       reg_wr,
	output logic [15:0]                reg_wdata,
	output logic                       reg_rd,
	input  wire logic [15:0]           reg_rdata
);

	import dhp_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);

	// Threshold field must be able to name a full buffer
	if (DEPTH + 1 > (1 << `DHP_CNT_W) || DEPTH < 2) begin : g_bad
		$error("dhp_port: DEPTH out of range for the count field");
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic              rd_act;
	logic              wr_act;
	logic              rd_q_r;
	logic              wr_q_r;
	logic              rd_end;
	logic              wr_end;
	logic              last_byte;
	logic              byte_hi_r;
	dhp_addr_t         addr_lat_r;
	dhp_addr_t         eff_addr;
	dhp_addr_t         reg_addr_r;
	logic              is_local;
	logic [15:0]       wbus_r;
	logic [7:0]        wlow_r;
	logic [15:0]       wword;
	logic              commit;
	logic [15:0]       config_r;
	logic [15:0]       int_en_r;
	logic [7:0]        status;
	logic              stat_clr;
	logic [15:0]       rword;
	logic [15:0]       data_out_r;
	logic [15:0]       data_oe_n_r;
	logic              fifo_valid;
	logic [15:0]       fifo_data;
	logic [CW-1:0]     fifo_count;
	logic              fifo_pop;
	logic              reg_wr_r;
	logic              reg_rd_r;
	logic [15:0]       reg_wdata_r;
	logic              int_n_r;
	logic              treq_r;
	logic              freeze_r;
	logic              strobe_q_r;
	logic              strobe_dir;
	logic              strobe_rise;
	dhp_trig_t         trig_r;
	logic              sh_hold_r;
	logic              start_conv_r;
	logic              start_cmp_r;
	logic              strobe_out_r;
	logic              strobe_oe_n_r;
	logic              go;

	// ------------------------------------------------------------------
	// Bus strobes and address
	// ------------------------------------------------------------------
	// Access qualifiers; select outside an access is the host's duty
	assign rd_act = ~rd_n & ~cs_n;
	assign wr_act = ~wr_n & ~cs_n;
	assign rd_end = rd_q_r & ~rd_act;
	assign wr_end = wr_q_r & ~wr_act;
	// Side effects only once the whole word has moved
	assign last_byte = ~bus_width_select | byte_hi_r;

	// A held-high strobe makes the lines transparent
	assign eff_addr = ale ? register_address_lines : addr_lat_r;
	assign is_local = (reg_addr_r == `DHP_OFS_CONFIG) ||
	                  (reg_addr_r == `DHP_OFS_INT_EN) ||
	                  (reg_addr_r == `DHP_OFS_INT_STAT) ||
	                  (reg_addr_r == `DHP_OFS_FIFO);

	// Follow the lines while the strobe is high; the low edge freezes
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			addr_lat_r <= '0;
		end else if (ale) begin
			addr_lat_r <= register_address_lines;
		end
	end

	// Access edge tracking and the address the access used
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rd_q_r     <= 1'b0;
			wr_q_r     <= 1'b0;
			reg_addr_r <= '0;
		end else begin
			rd_q_r <= rd_act;
			wr_q_r <= wr_act;
			if (rd_act || wr_act) begin
				reg_addr_r <= eff_addr;
			end
		end
	end

	// Byte phase on a narrow bus: low byte first, then high byte
	always_ff @(posedge clk_sys) begin
		if (!nrst || !bus_width_select) begin
			byte_hi_r <= 1'b0;
		end else if (rd_end || wr_end) begin
			byte_hi_r <= ~byte_hi_r;
		end
	end

	// ------------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------------
	// Last data seen during the strobe is what the write stores
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			wbus_r <= '0;
			wlow_r <= '0;
		end else begin
			if (wr_act) begin
				wbus_r <= data_in;
			end
			if (wr_end && bus_width_select && !byte_hi_r) begin
				wlow_r <= wbus_r[7:0];
			end
		end
	end

	assign commit = wr_end & last_byte;
	// Upper lines are ignored entirely on the narrow bus
	assign wword  = bus_width_select ? {wbus_r[7:0], wlow_r} : wbus_r;

	// Configuration and interrupt enable held here
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			config_r <= `DHP_CONFIG_RST;
			int_en_r <= `DHP_INT_EN_RST;
		end else if (commit) begin
			if (reg_addr_r == `DHP_OFS_CONFIG) begin
				config_r <= wword;
			end
			if (reg_addr_r == `DHP_OFS_INT_EN) begin
				int_en_r <= wword;
			end
		end
	end

	// Everything not held here is passed to the converter core
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reg_wr_r    <= 1'b0;
			reg_rd_r    <= 1'b0;
			reg_wdata_r <= '0;
		end else begin
			reg_wr_r <= commit & ~is_local;
			reg_rd_r <= rd_end & last_byte & ~is_local;
			if (commit) begin
				reg_wdata_r <= wword;
			end
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	// Read mux over every location on the address lines
	always_comb begin
		rword = reg_rdata;
		unique case (eff_addr)
			`DHP_OFS_CONFIG:   rword = config_r;
			`DHP_OFS_INT_EN:   rword = int_en_r;
			`DHP_OFS_INT_STAT: rword = {8'h00, status};
			`DHP_OFS_FIFO:     rword = fifo_data;
			default:           rword = reg_rdata;
		endcase
	end

	// Drivers on only inside an enabled read; one cycle of latency
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			data_out_r  <= '0;
			data_oe_n_r <= `DHP_OE_NONE;
		end else if (rd_act) begin
			data_out_r  <= (bus_width_select && byte_hi_r) ?
			               {8'h00, rword[15:8]} : rword;
			data_oe_n_r <= bus_width_select ? `DHP_OE_BYTE
			               : `DHP_OE_WORD;
		end else begin
			data_oe_n_r <= `DHP_OE_NONE;
		end
	end

	// Pop and clear at the end of the read so data holds meanwhile
	assign fifo_pop = rd_end & last_byte & (reg_addr_r == `DHP_OFS_FIFO);
	assign stat_clr = rd_end & last_byte &
	                  (reg_addr_r == `DHP_OFS_INT_STAT);

	// ------------------------------------------------------------------
	// Interrupt flags and request outputs
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			dhp_flag u_flag (
				.clk_sys (clk_sys),
				.nrst    (nrst),
				.set     (irq_event[gi]),
				.clr     (stat_clr),
				.flag_r  (status[gi])
			);
		end
	endgenerate

	// Threshold zero never requests, else an empty buffer would match
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			int_n_r <= 1'b1;
			treq_r  <= 1'b0;
		end else begin
			int_n_r <= ~|(status &
			    int_en_r[`DHP_IEN_MASK_MSB:`DHP_IEN_MASK_LSB]);
			if (fifo_count == '0) begin
				treq_r <= 1'b0;
			end else if (`DHP_CNT_W'(fifo_count) ==
			             int_en_r[`DHP_IEN_CNT_MSB:`DHP_IEN_CNT_LSB]) begin
				treq_r <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Result buffer
	// ------------------------------------------------------------------
	dhp_fifo #(
		.WIDTH (16),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.in_valid  (res_valid),
		.in_ready  (res_ready),
		.in_data   (res_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data),
		.count     (fifo_count)
	);

	// ------------------------------------------------------------------
	// Clock freeze and conversion strobe
	// ------------------------------------------------------------------
	assign strobe_dir  = config_r[`DHP_CFG_STROBE_DIR];
	assign strobe_rise = conv_strobe_in & ~strobe_q_r;
	// A start from hold waits out a freeze; a trigger edge or op_start during one is lost
	assign go          = ~freeze_r & cs_n;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			freeze_r   <= 1'b0;
			strobe_q_r <= 1'b0;
		end else begin
			freeze_r   <= ~cs_n;
			strobe_q_r <= conv_strobe_in;
		end
	end

	// Hold on the input edge, start on the next edge, run until done
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			trig_r       <= DHP_IDLE;
			sh_hold_r    <= 1'b0;
			start_conv_r <= 1'b0;
			start_cmp_r  <= 1'b0;
		end else begin
			sh_hold_r    <= 1'b0;
			start_conv_r <= 1'b0;
			start_cmp_r  <= 1'b0;
			unique case (trig_r)
				DHP_IDLE: begin
					if (!strobe_dir && strobe_rise && go) begin
						trig_r    <= DHP_HOLD;
						sh_hold_r <= 1'b1;
					end else if (strobe_dir && op_start && go) begin
						trig_r       <= DHP_RUN;
						start_conv_r <= ~instr_is_compare;
						start_cmp_r  <= instr_is_compare;
					end
				end
				DHP_HOLD: begin
					if (go) begin
						trig_r       <= DHP_RUN;
						start_conv_r <= ~instr_is_compare;
						start_cmp_r  <= instr_is_compare;
					end
				end
				DHP_RUN: begin
					if (op_done) begin
						trig_r <= DHP_IDLE;
					end
				end
			endcase
		end
	end

	// Output strobe spans the operation; released while an input
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			strobe_out_r  <= 1'b0;
			strobe_oe_n_r <= 1'b1;
		end else begin
			strobe_oe_n_r <= ~strobe_dir;
			if (start_conv_r || start_cmp_r) begin
				strobe_out_r <= 1'b1;
			end else if (op_done) begin
				strobe_out_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign data_out         = data_out_r;
	assign data_oe_n        = data_oe_n_r;
	assign conv_strobe_out  = strobe_out_r;
	assign conv_strobe_oe_n = strobe_oe_n_r;
	assign int_n            = int_n_r;
	assign transfer_request = treq_r;
	assign clk_freeze       = freeze_r;
	assign sh_hold          = sh_hold_r;
	assign start_conv       = start_conv_r;
	assign start_cmp        = start_cmp_r;
	assign reg_addr         = reg_addr_r;
	assign reg_wr           = reg_wr_r;
	assign reg_wdata        = reg_wdata_r;
	assign reg_rd           = reg_rd_r;

endmodule // dhp_port

// [verification/dhp_port_checker.sv]
// Checker: timing relations seen at the host bus port's pins.
// Assumes one clock and the synchronous active-low reset of the port.
`timescale 1ns/1ps

module dhp_port_checker (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        bus_width_select,
	input wire logic        cs_n,
	input wire logic        rd_n,
	input wire logic [15:0] data_oe_n,
	input wire logic        conv_strobe_oe_n,
	input wire logic        conv_strobe_out,
	input wire logic        int_n,
	input wire logic        transfer_request,
	input wire logic        clk_freeze,
	input wire logic        sh_hold,
	input wire logic        start_conv,
	input wire logic        start_cmp,
	input wire logic        instr_is_compare,
	input wire logic        op_done,
	input wire logic [7:0]  irq_event
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic rd_act;
	// Read window; drivers lag it by one edge
	assign rd_act = !rd_n && !cs_n;

	a_word_drive: assert property (
		$past(rd_act && !bus_width_select) |-> data_oe_n == 16'h0000)
		else $error("word read lanes wrong");
	a_byte_drive: assert property (
		$past(rd_act && bus_width_select) |-> data_oe_n == 16'hff00)
		else $error("byte read lanes wrong");
	a_bus_release: assert property (
		!$past(rd_act) |-> data_oe_n == 16'hffff)
		else $error("data lines driven outside read");
	a_reset_state: assert property (
		$past(!nrst) |-> conv_strobe_oe_n && int_n && !transfer_request)
		else $error("bad state after reset");
	a_freeze_follow: assert property (
		clk_freeze == $past(!cs_n))
		else $error("freeze does not follow select");
	a_hold_start: assert property (
		sh_hold |-> ##[1:30] (start_conv || start_cmp))
		else $error("no start after hold");
	a_start_kind: assert property (
		start_cmp |-> !start_conv && $past(instr_is_compare))
		else $error("wrong start kind");
	a_hold_input: assert property (
		sh_hold |-> conv_strobe_oe_n)
		else $error("hold while strobe is output");
	a_strobe_rise: assert property (
		(start_conv || start_cmp) && !conv_strobe_oe_n |=> conv_strobe_out)
		else $error("strobe did not rise");
	a_strobe_fall: assert property (
		op_done && !conv_strobe_oe_n |=> !conv_strobe_out)
		else $error("strobe did not fall");
	a_int_cause: assert property (
		$fell(int_n) |-> |$past(irq_event, 2))
		else $error("interrupt without cause");

	c_byte_read: cover property (rd_act && bus_width_select);
	c_int_low:   cover property ($fell(int_n));
	c_request:   cover property ($rose(transfer_request));
endmodule // dhp_port_checker

bind dhp_port dhp_port_checker u_chk (
	.clk_sys, .nrst, .bus_width_select, .cs_n, .rd_n, .data_oe_n,
	.conv_strobe_oe_n, .conv_strobe_out, .int_n, .transfer_request,
	.clk_freeze, .sh_hold, .start_conv, .start_cmp, .instr_is_compare,
	.op_done, .irq_event
);

// [verification/dhp_host_model.sv]
// Host model: microprocessor on a multiplexed or plain bus.
// Assumes the bench calls access() and sets mux by hierarchy.
`timescale 1ns/1ps

module dhp_host_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] data_out,
	input  wire logic [15:0] data_oe_n,
	output logic             cs_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic             ale,
	output logic [4:0]       addr_lines,
	output logic [15:0]      data_lines
);
	bit          mux = 1'b0;
	logic [15:0] wdat = 16'h0000;
	logic [15:0] idle_pat = 16'h5a5a;
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		ale = 1'b1;
		addr_lines = 5'h00;
	end
	// Released lines toggle so a stale value never passes for data
	always @(posedge clk_sys) idle_pat <= ~idle_pat;
	assign data_lines = wr_n ? idle_pat : wdat;

	// One bus cycle; strobes held until the data is taken
	task automatic access(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] rdat,
		output logic [15:0] oe);
		@(posedge clk_sys);
		ale <= 1'b1;
		addr_lines <= a;
		if (mux) begin
			@(posedge clk_sys);
			ale <= 1'b0;
			@(posedge clk_sys);
			addr_lines <= ~a; // Latched address must win
		end
		cs_n <= 1'b0;
		rd_n <= w;
		wr_n <= !w;
		wdat <= d;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		rdat = data_out;
		oe = data_oe_n;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		ale <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask
endmodule // dhp_host_model

// [verification/daq_host_bus_port_bench.sv]
// Bench: host bus port against a queue-based reference model.
// Assumes design files and the host model are compiled before it.
`timescale 1ns/1ps
`include "dhp_regs.svh"

module daq_host_bus_port_bench;
	import dhp_pkg::*;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        bus_width_select = 1'b0;
	logic        cs_n, rd_n, wr_n, ale, conv_strobe_out, conv_strobe_oe_n;
	logic        int_n, transfer_request, clk_freeze, sh_hold, start_conv;
	logic        start_cmp, res_ready, reg_wr, reg_rd;
	logic        conv_strobe_in = 1'b0, instr_is_compare = 1'b0;
	logic        op_start = 1'b0, op_done = 1'b0, res_valid = 1'b0;
	logic [7:0]  irq_event = 8'h00;
	logic [15:0] res_data = 16'h0000, data_in, data_out, data_oe_n;
	logic [15:0] reg_wdata, reg_rdata, rdat, oe, v;
	dhp_addr_t   addr, reg_addr;
	int          num_errors = 0, comparisons = 0, i, k, thr;
	bit          took, seen, fwd;
	logic [15:0] fifo_q[$];

	always #5 clk_sys = ~clk_sys;
	// Core read data: a fixed function of the forwarded address
	assign reg_rdata = {11'h000, reg_addr} ^ 16'hc3c3;

	dhp_port #(.DEPTH(16)) dut (.clk_sys, .nrst, .bus_width_select,
		.cs_n, .rd_n, .wr_n, .ale, .register_address_lines(addr),
		.data_in, .data_out, .data_oe_n, .conv_strobe_in,
		.conv_strobe_out, .conv_strobe_oe_n, .int_n, .transfer_request,
		.clk_freeze, .sh_hold, .start_conv, .start_cmp, .instr_is_compare,
		.op_start, .op_done, .irq_event, .res_valid, .res_ready,
		.res_data, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
	dhp_host_model host (.clk_sys, .data_out, .data_oe_n, .cs_n, .rd_n,
		.wr_n, .ale, .addr_lines(addr), .data_lines(data_in));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// A wait that ran out ends the run at once
	task automatic bound(input bit ok, input string what);
		if (!ok) begin
			$display("FAIL %s expected 1 seen 0", what);
			num_errors++;
			end_sim();
		end
	endtask
	// The forwarded strobe lasts one cycle, so it is watched during the access
	task automatic acc(input logic w, input dhp_addr_t a, input logic [15:0] d);
		fork
			host.access(w, a, d, rdat, oe);
			begin
				fwd = 1'b0;
				repeat (12) @(negedge clk_sys) fwd |= w ? reg_wr : reg_rd;
			end
		join
	endtask
	// Result push; a refused word is withdrawn, not retried
	task automatic push(input logic [15:0] d);
		@(posedge clk_sys);
		res_valid <= 1'b1;
		res_data <= d;
		@(negedge clk_sys);
		took = res_ready;
		@(posedge clk_sys);
		res_valid <= 1'b0;
		chk("buffer space", fifo_q.size() < 16, took);
		if (took) fifo_q.push_back(d);
	endtask
	// One-cycle pulse on {op_start, op_done, irq_event}
	task automatic pulse(input logic [9:0] p);
		@(posedge clk_sys);
		{op_start, op_done, irq_event} <= p;
		@(posedge clk_sys);
		{op_start, op_done, irq_event} <= 10'h000;
	endtask

	initial begin
		void'($urandom(32'h511d));
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		@(negedge clk_sys);
		chk("data drivers", 16'hffff, data_oe_n);
		chk("strobe direction", 1'b1, conv_strobe_oe_n);
		chk("interrupt idle", 1'b1, int_n);
		$display("test reset done");
		// Fill past full over a latched address, then drain to empty
		host.mux = 1'b1;
		thr = 5;
		acc(1'b1, `DHP_OFS_INT_EN, 16'h0500);
		for (i = 0; i < 17; i++) begin
			push(16'($urandom));
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("request fill", fifo_q.size() >= thr, transfer_request);
		end
		while (fifo_q.size() > 0) begin
			acc(1'b0, `DHP_OFS_FIFO, 16'h0000);
			chk("buffer word", fifo_q.pop_front(), rdat);
			chk("word lanes", 16'h0000, oe);
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("request drain", fifo_q.size() > 0, transfer_request);
		end
		host.mux = 1'b0;
		$display("test buffer done");
		bus_width_select <= 1'b1;
		push(16'($urandom));
		push(16'($urandom));
		for (i = 0; i < 2; i++) begin
			v = fifo_q.pop_front();
			acc(1'b0, `DHP_OFS_FIFO, 16'h0000);
			chk("low byte", v[7:0], rdat[7:0]);
			chk("byte lanes", 16'hff00, oe);
			acc(1'b0, `DHP_OFS_FIFO, 16'h0000);
			chk("high byte", v[15:8], rdat[7:0]);
		end
		bus_width_select <= 1'b0;
		$display("test byte bus done");
		for (i = 0; i < 8; i++) begin
			acc(1'b1, `DHP_OFS_INT_EN, 16'h0001 << i);
			pulse({2'b00, 8'h01 << ((i + 1) % 8)});
			repeat (4) @(negedge clk_sys);
			chk("masked condition", 1'b1, int_n);
			pulse({2'b00, 8'h01 << i});
			@(negedge clk_sys);
			for (k = 0; k < 6 && int_n; k++) @(negedge clk_sys);
			bound(!int_n, "unmasked condition");
			acc(1'b0, `DHP_OFS_INT_STAT, 16'h0000);
			chk("status", (8'h01 << i) | (8'h01 << ((i + 1) % 8)),
				rdat[7:0]);
			chk("no forwarded read", 1'b0, fwd);
			repeat (2) @(negedge clk_sys);
			chk("interrupt released", 1'b1, int_n);
		end
		$display("test interrupt done");
		for (i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			instr_is_compare <= i[0];
			conv_strobe_in <= 1'b1;
			@(negedge clk_sys);
			for (k = 0; k < 6 && !sh_hold; k++) @(negedge clk_sys);
			bound(sh_hold, "hold pulse");
			for (k = 0; k < 6 && !(start_conv | start_cmp); k++)
				@(negedge clk_sys);
			chk("start kind", {i[0], !i[0]}, {start_cmp, start_conv});
			@(posedge clk_sys);
			conv_strobe_in <= 1'b0;
			pulse(10'h100);
		end
		// A trigger edge inside an access is dropped
		fork
			acc(1'b0, `DHP_OFS_INT_STAT, 16'h0000);
			begin @(posedge clk_sys); conv_strobe_in <= 1'b1; end
			begin seen = 0; repeat (10) @(negedge clk_sys) seen |= sh_hold; end
		join
		chk("frozen trigger", 1'b0, seen);
		@(posedge clk_sys);
		conv_strobe_in <= 1'b0;
		acc(1'b1, `DHP_OFS_CONFIG, 16'h0001);
		repeat (2) @(negedge clk_sys);
		chk("strobe driven", 1'b0, conv_strobe_oe_n);
		pulse(10'h200);
		repeat (2) @(negedge clk_sys);
		chk("strobe high", 1'b1, conv_strobe_out);
		pulse(10'h100);
		repeat (2) @(negedge clk_sys);
		chk("strobe low", 1'b0, conv_strobe_out);
		acc(1'b1, `DHP_OFS_CONFIG, 16'h0000);
		$display("test strobe done");
		for (i = 0; i < 2; i++) begin
			host.mux = i[0];
			v = 16'($urandom);
			k = $urandom_range(7);
			acc(1'b1, 5'(k), v);
			chk("forwarded write", 1'b1, fwd);
			chk("write address", k, reg_addr);
			chk("write data", v, reg_wdata);
			acc(1'b0, 5'(k), 16'h0000);
			chk("forwarded read", {11'h000, 5'(k)} ^ 16'hc3c3, rdat);
			chk("read strobe", 1'b1, fwd);
		end
		$display("test forwarding done");
		end_sim();
	end
endmodule // daq_host_bus_port_bench
